// ### rtl/crt_pkg.sv
package crt_pkg;
	// ---------------------------------------------------------------
	// Register word indices (compared with byte address bits 9-2)
	// ---------------------------------------------------------------
	// Printed offsets are not multiples of four, so each is an index.
	localparam logic [7:0] IDX_TIMER_CONTROL = 8'hc8;
	localparam logic [7:0] IDX_CAPTURE_RELOAD_LOW = 8'hca;
	localparam logic [7:0] IDX_CAPTURE_RELOAD_HIGH = 8'hcb;
	localparam logic [7:0] IDX_COUNT_LOW_BYTE = 8'hcc;
	localparam logic [7:0] IDX_COUNT_HIGH_BYTE = 8'hcd;
	localparam logic [7:0] IDX_TICK_CONFIG = 8'hd0;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'hd1;
	localparam logic [7:0] IDX_IRQ_ENABLE = 8'hd2;
	localparam logic [7:0] IDX_IRQ_CLEAR = 8'hd3;
	localparam int ADDR_W = 10;
	// ---------------------------------------------------------------
	// Control field positions
	// ---------------------------------------------------------------
	localparam int BIT_OVERFLOW_FLAG = 7;
	localparam int BIT_EXT_EDGE_FLAG = 6;
	localparam int BIT_RX_BAUD_SOURCE = 5;
	localparam int BIT_TX_BAUD_SOURCE = 4;
	localparam int BIT_EXT_EDGE_ENABLE = 3;
	localparam int BIT_RUN_CONTROL = 2;
	localparam int BIT_COUNT_SOURCE = 1;
	localparam int BIT_CAPTURE_RELOAD = 0;
	// Irq status bits: overflow event, external edge event
	localparam int IRQ_OVERFLOW = 0;
	localparam int IRQ_EXT_EDGE = 1;
	// ---------------------------------------------------------------
	// Reset values and timing
	// ---------------------------------------------------------------
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [1:0] RESET_IRQ = 2'h0;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	localparam int BAUD_DIV = 2;
	localparam int SLOW_TICK_DIV = 12;
	localparam int DIV_W = 4;
endpackage

// ### rtl/crt_timer.sv
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - Overflow flag sets when count rolls over from ffff; software clears it.
// - Overflow flag sets only while both baud-source bits are zero.
// - Software writing one to overflow flag raises timer interrupt if enabled.
// - External flag sets on capture pin falling edge when edge enable is one.
// - Software setting the external flag raises timer interrupt if enabled.
// - Receive baud-source bit picks this timer or timer 1 for serial rx.
// - Transmit baud-source bit picks this timer or timer 1 for serial tx.
// - In baud mode the timer advances every 2 clocks, ignoring count source.
// - Capture pin edges ignored when edge enable is zero or in baud mode.
// - Run bit one operates; zero halts counting, but an enabled capture pin edge with select zero still reloads.
// - Count source zero counts clock ticks at speed-bit rate; one counts pin.
// - In baud mode capture/reload select is ignored; reload on overflow.
// - Select zero reloads on overflow and on enabled capture pin edge.
// - Select one with edge enable captures the count on capture pin edge.
// - Capture copies count low byte to low, high byte to high register.
// - Reload value is high capture register over low capture register.
// - Low count register holds count bits 7-0, high holds bits 15-8.
module crt_timer #(
	parameter int SLOW_DIV = crt_pkg::SLOW_TICK_DIV
) (
	// Clock, reset, enable
	input wire logic clock,
	input wire logic rst_b,
	input wire logic clk_en,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [crt_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Pins
	input wire logic ext_count_pin,
	input wire logic ext_capture_pin,
	// Serial port baud clocks
	input wire logic timer1_overflow,
	output logic rx_baud_tick,
	output logic tx_baud_tick,
	// Interrupt
	output logic irq
);
	import crt_pkg::*;

	// The prescaler must be able to hold SLOW_DIV - 1
	if (SLOW_DIV < 1 || SLOW_DIV > 2 ** DIV_W)
	begin : g_div_check
		$error("SLOW_DIV out of range");
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [7:0] timer_control;
	logic [7:0] capture_reload_low;
	logic [7:0] capture_reload_high;
	logic [15:0] count;
	logic tick_rate_select;
	logic [1:0] irq_status;
	logic [1:0] irq_enable;
	logic [1:0] irq_pend;

	logic overflow_flag, ext_edge_flag, rx_src, tx_src, ext_edge_enable;
	logic run_control, count_source_select, capture_reload_select;
	assign overflow_flag = timer_control[BIT_OVERFLOW_FLAG];
	assign ext_edge_flag = timer_control[BIT_EXT_EDGE_FLAG];
	assign rx_src = timer_control[BIT_RX_BAUD_SOURCE];
	assign tx_src = timer_control[BIT_TX_BAUD_SOURCE];
	assign ext_edge_enable = timer_control[BIT_EXT_EDGE_ENABLE];
	assign run_control = timer_control[BIT_RUN_CONTROL];
	assign count_source_select = timer_control[BIT_COUNT_SOURCE];
	assign capture_reload_select = timer_control[BIT_CAPTURE_RELOAD];

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	logic req, wr, rd_ok;
	logic [7:0] idx;
	logic [7:0] wbyte;
	// Masking with ack keeps a strobe held past ack from being taken twice
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = req && wb_we_i && wb_sel_i[0];
	assign idx = wb_adr_i[ADDR_W-1:2];
	assign wbyte = wb_dat_i[7:0];

	function automatic logic hit(input logic [7:0] a, input logic [7:0] i);
		hit = (a == i);
	endfunction

	logic wr_ctl, wr_cl, wr_ch, wr_tl, wr_th, wr_cfg, wr_en, wr_clr;
	assign wr_ctl = wr && hit(idx, IDX_TIMER_CONTROL);
	assign wr_cl = wr && hit(idx, IDX_CAPTURE_RELOAD_LOW);
	assign wr_ch = wr && hit(idx, IDX_CAPTURE_RELOAD_HIGH);
	assign wr_tl = wr && hit(idx, IDX_COUNT_LOW_BYTE);
	assign wr_th = wr && hit(idx, IDX_COUNT_HIGH_BYTE);
	assign wr_cfg = wr && hit(idx, IDX_TICK_CONFIG);
	assign wr_en = wr && hit(idx, IDX_IRQ_ENABLE);
	assign wr_clr = wr && hit(idx, IDX_IRQ_CLEAR);

	// ---------------------------------------------------------------
	// Pin synchronisers and falling edges
	// ---------------------------------------------------------------
	logic [1:0] cnt_sync;
	logic [1:0] cap_sync;
	logic cnt_prev, cap_prev;
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			cnt_sync <= 2'h3;
			cap_sync <= 2'h3;
			cnt_prev <= 1'b1;
			cap_prev <= 1'b1;
		end
		else if (clk_en)
		begin
			cnt_sync <= {cnt_sync[0], ext_count_pin};
			cap_sync <= {cap_sync[0], ext_capture_pin};
			cnt_prev <= cnt_sync[1];
			cap_prev <= cap_sync[1];
		end
	end
	logic cnt_fall, cap_fall;
	assign cnt_fall = cnt_prev && !cnt_sync[1];
	assign cap_fall = cap_prev && !cap_sync[1];

	// ---------------------------------------------------------------
	// Tick generation
	// ---------------------------------------------------------------
	logic baud_mode;
	assign baud_mode = rx_src || tx_src;
	logic [DIV_W-1:0] prescale;
	// Baud phase runs free, so setting a source bit needs no restart
	logic baud_phase;
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			prescale <= '0;
			baud_phase <= 1'b0;
		end
		else if (clk_en)
		begin
			baud_phase <= !baud_phase;
			if (prescale == DIV_W'(SLOW_DIV - 1))
				prescale <= '0;
			else
				prescale <= prescale + 1'b1;
		end
	end

	logic tick;
	always_comb
	begin
		if (!run_control)
			tick = 1'b0;
		else if (baud_mode)
			tick = baud_phase;
		else if (count_source_select)
			tick = cnt_fall;
		else if (tick_rate_select)
			tick = 1'b1;
		else
			tick = (prescale == '0);
	end

	// ---------------------------------------------------------------
	// Count, capture, reload
	// ---------------------------------------------------------------
	logic overflow, edge_ok, do_capture, do_reload;
	logic [15:0] reload_value;
	assign overflow = tick && (count == COUNT_MAX);
	assign edge_ok = cap_fall && ext_edge_enable && !baud_mode;
	assign do_capture = edge_ok && capture_reload_select;
	assign do_reload = overflow && (baud_mode || !capture_reload_select)
		|| edge_ok && !capture_reload_select;
	assign reload_value = {capture_reload_high, capture_reload_low};

	always_ff @(posedge clock)
	begin
		if (!rst_b)
			count <= {RESET_BYTE, RESET_BYTE};
		else if (clk_en)
		begin
			// A reload beats a software byte write in the same cycle
			if (do_reload)
				count <= reload_value;
			else if (wr_tl)
				count[7:0] <= wbyte;
			else if (wr_th)
				count[15:8] <= wbyte;
			else if (tick)
				count <= count + 16'h0001;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			capture_reload_low <= RESET_BYTE;
			capture_reload_high <= RESET_BYTE;
		end
		else if (clk_en)
		begin
			// Capture beats a software write so no sampled count is lost
			if (do_capture)
			begin
				capture_reload_low <= count[7:0];
				capture_reload_high <= count[15:8];
			end
			else if (wr_cl)
				capture_reload_low <= wbyte;
			else if (wr_ch)
				capture_reload_high <= wbyte;
		end
	end

	// ---------------------------------------------------------------
	// Control register and flags
	// ---------------------------------------------------------------
	logic hw_ovf, hw_ext;
	assign hw_ovf = overflow && !baud_mode;
	assign hw_ext = edge_ok;
	always_ff @(posedge clock)
	begin
		if (!rst_b)
			timer_control <= RESET_BYTE;
		else if (clk_en)
		begin
			if (wr_ctl)
				timer_control <= wbyte;
			// Hardware set wins over a software clear
			if (hw_ovf)
				timer_control[BIT_OVERFLOW_FLAG] <= 1'b1;
			if (hw_ext)
				timer_control[BIT_EXT_EDGE_FLAG] <= 1'b1;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
			tick_rate_select <= 1'b0;
		else if (clk_en && wr_cfg)
			tick_rate_select <= wbyte[0];
	end

	// ---------------------------------------------------------------
	// Interrupts
	// ---------------------------------------------------------------
	// A software write of one to a flag counts as an event too.
	logic sw_ovf, sw_ext;
	assign sw_ovf = wr_ctl && wbyte[BIT_OVERFLOW_FLAG];
	assign sw_ext = wr_ctl && wbyte[BIT_EXT_EDGE_FLAG];
	assign irq_pend = {hw_ext || sw_ext, hw_ovf || sw_ovf};

	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			irq_status <= RESET_IRQ;
			irq_enable <= RESET_IRQ;
			irq <= 1'b0;
		end
		else if (clk_en)
		begin
			if (wr_en)
				irq_enable <= wbyte[1:0];
			irq_status <= (irq_status & ~(wr_clr ? wbyte[1:0] : 2'h0))
				| irq_pend;
			// Registered, so irq trails the status bit by one cycle
			irq <= |(irq_status & irq_enable);
		end
	end

	// ---------------------------------------------------------------
	// Baud clocks to serial port 0
	// ---------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			rx_baud_tick <= 1'b0;
			tx_baud_tick <= 1'b0;
		end
		else if (clk_en)
		begin
			rx_baud_tick <= rx_src ? overflow : timer1_overflow;
			tx_baud_tick <= tx_src ? overflow : timer1_overflow;
		end
	end

	// ---------------------------------------------------------------
	// Read data and acknowledge
	// ---------------------------------------------------------------
	logic [7:0] rbyte;
	always_comb
	begin
		rd_ok = 1'b1;
		if (hit(idx, IDX_TIMER_CONTROL))
			rbyte = timer_control;
		else if (hit(idx, IDX_CAPTURE_RELOAD_LOW))
			rbyte = capture_reload_low;
		else if (hit(idx, IDX_CAPTURE_RELOAD_HIGH))
			rbyte = capture_reload_high;
		else if (hit(idx, IDX_COUNT_LOW_BYTE))
			rbyte = count[7:0];
		else if (hit(idx, IDX_COUNT_HIGH_BYTE))
			rbyte = count[15:8];
		else if (hit(idx, IDX_TICK_CONFIG))
			rbyte = {7'h00, tick_rate_select};
		else if (hit(idx, IDX_IRQ_STATUS))
			rbyte = {6'h00, irq_status};
		else if (hit(idx, IDX_IRQ_ENABLE))
			rbyte = {6'h00, irq_enable};
		else
		begin
			rbyte = 8'h00;
			rd_ok = 1'b0;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else if (clk_en)
		begin
			wb_ack_o <= req;
			wb_dat_o <= (req && !wb_we_i && rd_ok) ? {24'h000000, rbyte}
				: 32'h0000_0000;
		end
	end
endmodule // crt_timer

// ### dv/crt_chk.sv
`timescale 1ns/1ps
module crt_chk (
	// Clock and control
	input wire logic clock,
	input wire logic rst_b,
	input wire logic clk_en,
	// Register bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [crt_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Baud and interrupt
	input wire logic timer1_overflow,
	input wire logic rx_baud_tick,
	input wire logic tx_baud_tick,
	input wire logic irq
);
	import crt_pkg::*;
	logic take;
	logic rx_own;
	logic tx_own;
	logic [1:0] ien;
	assign take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && clk_en
		&& wb_sel_i[0];
	// ----------
	// Shadow of baud steering and irq enable, kept from bus writes
	// ----------
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			rx_own <= 1'b0;
			tx_own <= 1'b0;
			ien <= 2'h0;
		end
		else if (take && wb_adr_i[9:2] == IDX_TIMER_CONTROL)
		begin
			rx_own <= wb_dat_i[BIT_RX_BAUD_SOURCE];
			tx_own <= wb_dat_i[BIT_TX_BAUD_SOURCE];
		end
		else if (take && wb_adr_i[9:2] == IDX_IRQ_ENABLE)
			ien <= wb_dat_i[1:0];
	end
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		&& clk_en |=> wb_ack_o) else $error("ack late");
	ack_pulse_a: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
		else $error("ack held");
	ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
		else $error("ack unasked");
	upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper data set");
	write_data_a: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0)
		else $error("write data set");
	rx_source_a: assert property (!rx_own && clk_en |=>
		rx_baud_tick == $past(timer1_overflow)) else $error("rx tick");
	tx_source_a: assert property (!tx_own && clk_en |=>
		tx_baud_tick == $past(timer1_overflow)) else $error("tx tick");
	irq_mask_a: assert property (ien == 2'h0 && clk_en |=> !irq)
		else $error("irq unmasked");
endmodule // crt_chk

// ### dv/crt_pins.sv
`timescale 1ns/1ps
module crt_pins (
	// Clock
	input wire logic clock,
	// Pins and timer 1
	output logic ext_count_pin,
	output logic ext_capture_pin,
	output logic timer1_overflow
);
	// Pins rest high as if pulled up
	initial
	begin
		ext_count_pin = 1'b1;
		ext_capture_pin = 1'b1;
		timer1_overflow = 1'b0;
	end
	// Four cycles per level, above the synchroniser's three
	task automatic fall(input logic [1:0] m);
		ext_capture_pin <= !m[0];
		ext_count_pin <= !m[1];
		repeat (4) @(posedge clock);
		ext_capture_pin <= 1'b1;
		ext_count_pin <= 1'b1;
		repeat (4) @(posedge clock);
	endtask
	task automatic t1();
		timer1_overflow <= 1'b1;
		@(posedge clock);
		timer1_overflow <= 1'b0;
		repeat (2) @(posedge clock);
	endtask
endmodule // crt_pins

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	import crt_pkg::*;
	logic clock, rst_b, clk_en, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [ADDR_W-1:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic ext_count_pin, ext_capture_pin, timer1_overflow;
	logic rx_baud_tick, tx_baud_tick, irq;
	logic [7:0] rd;
	logic [7:0] idx0 [10] = '{8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hd0,
		8'hd1, 8'hd2, 8'hd3, 8'h10};
	int n_errors, tests_run, n_rx, n_tx, a, b;
	crt_timer #(.SLOW_DIV(2)) u_dut (.*);
	crt_pins u_pins (.*);
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	always @(posedge clock)
	begin
		n_rx <= n_rx + int'(rx_baud_tick);
		n_tx <= n_tx + int'(tx_baud_tick);
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ----------
	// Classic bus cycle, held until ack is sampled
	// ----------
	task automatic wb(input logic w, input logic [7:0] x, input logic [7:0] d);
		int i;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {x, 2'b00};
		wb_dat_i <= {24'h0, d};
		for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++)
			@(posedge clock);
		rd = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clock);
		if (i == 20)
		begin
			n_errors++;
			give_verdict();
		end
	endtask
	task automatic wr(input logic [7:0] x, input logic [7:0] d);
		wb(1'b1, x, d);
	endtask
	task automatic rc(input logic [7:0] x, input logic [7:0] e);
		wb(1'b0, x, 8'h00);
		check(rd, e);
	endtask
	task automatic ck_irq(input logic e);
		check({7'h0, irq}, {7'h0, e});
	endtask
	initial
	begin
		{rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
		clk_en = 1'b1;
		wb_sel_i = 4'hf;
		repeat (5) @(posedge clock);
		rst_b <= 1'b1;
		wr(8'h10, 8'hff);
		foreach (idx0[i])
			rc(idx0[i], 8'h00);
		$display("test reset done");
		wr(IDX_COUNT_HIGH_BYTE, 8'h12);
		wr(IDX_COUNT_LOW_BYTE, 8'h34);
		wr(IDX_IRQ_ENABLE, 8'h02);
		wr(IDX_TIMER_CONTROL, 8'h09);
		u_pins.fall(2'b01);
		rc(IDX_CAPTURE_RELOAD_LOW, 8'h34);
		rc(IDX_CAPTURE_RELOAD_HIGH, 8'h12);
		rc(IDX_TIMER_CONTROL, 8'h49);
		rc(IDX_IRQ_STATUS, 8'h02);
		ck_irq(1'b1);
		rc(IDX_COUNT_LOW_BYTE, 8'h34);
		wr(IDX_TIMER_CONTROL, 8'h01);
		wr(IDX_IRQ_CLEAR, 8'h02);
		u_pins.fall(2'b01);
		rc(IDX_TIMER_CONTROL, 8'h01);
		rc(IDX_IRQ_STATUS, 8'h00);
		ck_irq(1'b0);
		$display("test capture done");
		wr(IDX_CAPTURE_RELOAD_LOW, 8'h56);
		wr(IDX_CAPTURE_RELOAD_HIGH, 8'h78);
		wr(IDX_TIMER_CONTROL, 8'h08);
		u_pins.fall(2'b01);
		rc(IDX_COUNT_LOW_BYTE, 8'h56);
		rc(IDX_COUNT_HIGH_BYTE, 8'h78);
		wr(IDX_TIMER_CONTROL, 8'h00);
		wr(IDX_IRQ_CLEAR, 8'h02);
		$display("test edge reload done");
		wr(IDX_TICK_CONFIG, 8'h01);
		wr(IDX_CAPTURE_RELOAD_LOW, 8'hf0);
		wr(IDX_CAPTURE_RELOAD_HIGH, 8'hff);
		wr(IDX_COUNT_LOW_BYTE, 8'hfe);
		wr(IDX_COUNT_HIGH_BYTE, 8'hff);
		wr(IDX_IRQ_ENABLE, 8'h01);
		wr(IDX_TIMER_CONTROL, 8'h04);
		repeat (4) @(posedge clock);
		rc(IDX_TIMER_CONTROL, 8'h84);
		rc(IDX_IRQ_STATUS, 8'h01);
		ck_irq(1'b1);
		wr(IDX_TIMER_CONTROL, 8'h80);
		rc(IDX_COUNT_HIGH_BYTE, 8'hff);
		wr(IDX_TIMER_CONTROL, 8'h00);
		wr(IDX_IRQ_CLEAR, 8'h01);
		$display("test overflow done");
		wr(IDX_IRQ_ENABLE, 8'h03);
		wr(IDX_TIMER_CONTROL, 8'hc0);
		repeat (3) @(posedge clock);
		ck_irq(1'b1);
		rc(IDX_IRQ_STATUS, 8'h03);
		wr(IDX_TIMER_CONTROL, 8'h00);
		wr(IDX_IRQ_CLEAR, 8'h03);
		repeat (3) @(posedge clock);
		ck_irq(1'b0);
		$display("test forced flags done");
		wr(IDX_COUNT_LOW_BYTE, 8'h00);
		wr(IDX_COUNT_HIGH_BYTE, 8'h00);
		wr(IDX_TIMER_CONTROL, 8'h06);
		a = n_rx;
		b = n_tx;
		repeat (3)
		begin
			u_pins.fall(2'b10);
			u_pins.t1();
		end
		rc(IDX_COUNT_LOW_BYTE, 8'h03);
		rc(IDX_COUNT_HIGH_BYTE, 8'h00);
		check(8'(n_rx - a), 8'h03);
		check(8'(n_tx - b), 8'h03);
		$display("test pin count done");
		wr(IDX_TIMER_CONTROL, 8'h00);
		wr(IDX_CAPTURE_RELOAD_LOW, 8'hfe);
		wr(IDX_COUNT_LOW_BYTE, 8'hff);
		wr(IDX_COUNT_HIGH_BYTE, 8'hff);
		wr(IDX_TIMER_CONTROL, 8'h3d);
		repeat (8) @(posedge clock);
		a = n_rx;
		b = n_tx;
		repeat (40) @(posedge clock);
		check(8'(n_rx - a), 8'h0a);
		check(8'(n_tx - b), 8'h0a);
		u_pins.fall(2'b01);
		rc(IDX_TIMER_CONTROL, 8'h3d);
		rc(IDX_CAPTURE_RELOAD_LOW, 8'hfe);
		wb_sel_i <= 4'he;
		wr(IDX_CAPTURE_RELOAD_LOW, 8'h11);
		wb_sel_i <= 4'hf;
		rc(IDX_CAPTURE_RELOAD_LOW, 8'hfe);
		wr(IDX_TIMER_CONTROL, 8'h00);
		$display("test baud done");
		wr(IDX_COUNT_LOW_BYTE, 8'h00);
		wr(IDX_COUNT_HIGH_BYTE, 8'h00);
		wr(IDX_TIMER_CONTROL, 8'h04);
		clk_en <= 1'b0;
		repeat (10) @(posedge clock);
		clk_en <= 1'b1;
		wr(IDX_TIMER_CONTROL, 8'h00);
		rc(IDX_COUNT_LOW_BYTE, 8'h03);
		$display("test freeze done");
		wr(IDX_TICK_CONFIG, 8'h00);
		wr(IDX_COUNT_LOW_BYTE, 8'h00);
		wr(IDX_TIMER_CONTROL, 8'h04);
		repeat (17) @(posedge clock);
		wr(IDX_TIMER_CONTROL, 8'h00);
		rc(IDX_COUNT_LOW_BYTE, 8'h0a);
		$display("test slow tick done");
		give_verdict();
	end
endmodule // testbench
bind crt_timer crt_chk u_chk (.*);
